// File: hdl/flmc_pkg.sv
package flmc_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
    localparam logic [7:0] REG_AUDIO      = 8'h10;

    // Control register fields
    localparam int CTRL_MUTE_BIT   = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // Status register fields above the five fault bits
    localparam int STAT_SHDN_BIT   = 8;
    localparam int STAT_SEL_BIT    = 9;
    localparam int STAT_FAULT_BIT  = 10;
    localparam int STAT_HIZ_BIT    = 11;

    // Audio register: left sample low byte, right sample next byte
    localparam int AUDIO_L_LSB = 0;
    localparam int AUDIO_R_LSB = 8;

    // Carrier and duty figures
    localparam int CARRIER_W    = 8;
    localparam int IDLE_PERCENT = 15;
    localparam int HALF_PERCENT = 50;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Protection events, one bit each; also the interrupt layout
    typedef struct packed {
        logic ovr_volt;   // Supply too high, self-clearing
        logic undr_volt;  // Supply too low, self-clearing
        logic dc_offset;  // Output offset too high, latched
        logic over_temp;  // Die above trip point, latched
        logic short_ckt;  // Output over-current, latched
    } flmc_evt_s;

    localparam int EVT_W = $bits(flmc_evt_s);
    localparam int LATCH_N = 3;

    // Bridge state, one-hot
    typedef enum logic [1:0] {
        BR_HIZ = 2'h1,
        BR_RUN = 2'h2
    } flmc_bridge_e;

endpackage

// File: hdl/flmc_fault_latch.sv
`timescale 1ns/1ps
`default_nettype none

// Sticky fault flag, set has priority over clear
module flmc_fault_latch (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set_i,
    input  wire logic clr_i,
    output var  logic latched_q
);

    // Set beats clear so an event during clearing is not lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_q <= 1'b0;
        end else if (set_i) begin
            latched_q <= 1'b1;
        end else if (clr_i) begin
            latched_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: hdl/flmc_pwm_ch.sv
`timescale 1ns/1ps
`default_nettype none

// One bridge channel: signed sample to positive and negative half duty
module flmc_pwm_ch #(
    parameter int W = flmc_pkg::CARRIER_W
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                step_en,   // Carrier advance pulse
    input  wire logic                single_md, // High selects single-side switching
    input  wire logic signed [W-1:0] sample,
    output var  logic                pos_q,
    output var  logic                neg_q
);

    localparam int FULL = 1 << W;
    localparam logic signed [W+1:0] HALF =
        (W+2)'(FULL * flmc_pkg::HALF_PERCENT / 100);
    localparam logic signed [W+1:0] IDLE =
        (W+2)'(FULL * flmc_pkg::IDLE_PERCENT / 100);
    localparam logic signed [W+1:0] TOP = (W+2)'(FULL);

    logic        [W-1:0] cnt_q;          // Carrier ramp
    logic signed [W+1:0] pos_th_q;       // Thresholds held for a period
    logic signed [W+1:0] neg_th_q;
    logic signed [W+1:0] pos_th_d;
    logic signed [W+1:0] neg_th_d;
    logic signed [W+1:0] s_ext;

    // Clamp a threshold into the carrier range
    function automatic logic signed [W+1:0] clamp(input logic signed [W+1:0] v);
        if (v < 0) begin
            clamp = '0;
        end else if (v > TOP) begin
            clamp = TOP;
        end else begin
            clamp = v;
        end
    endfunction

    // Duty law for both schemes
    always_comb begin
        s_ext = (W+2)'(sample);
        if (single_md) begin
            // Idle at the low duty; the falling side rails to zero first
            pos_th_d = clamp(IDLE + s_ext);
            neg_th_d = clamp(IDLE - s_ext);
        end else begin
            // Centred on half duty, equal and opposite swing
            pos_th_d = clamp(HALF + (s_ext >>> 1));
            neg_th_d = clamp(HALF - (s_ext >>> 1));
        end
    end

    // Carrier ramp; thresholds load at wrap so no pulse is cut short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= '0;
            pos_th_q <= HALF;
            neg_th_q <= HALF;
        end else if (step_en) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == '1) begin
                pos_th_q <= pos_th_d;
                neg_th_q <= neg_th_d;
            end
        end
    end

    // Both halves rise at carrier start, so idle edges stay in phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else begin
            pos_q <= ((W+2)'(cnt_q) < pos_th_q);
            neg_q <= ((W+2)'(cnt_q) < neg_th_q);
        end
    end

endmodule

`default_nettype wire

// File: hdl/flmc_top.sv
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Short-circuit latches and pulls fault output low
// - Short-circuit latch keeps bridge outputs high-impedance
// - Shutdown low pulse alone clears latches
// - Over-temperature flag latches, shuts down outputs
// - Over-temperature pulls fault low, same clear
// - Select low in-phase, high single-side
// - In-phase: halves rail-to-rail, idle in phase
// - In-phase: duty above/below half by polarity
// - Single-side: about fifteen percent idle duty
// - Single-side: falling half grounds, other modulates
// - Offset latches with fault; supply faults self-clear
module flmc_top #(
    parameter int CH_N    = 2,                    // Stereo channels
    parameter int PWM_DIV = 1,                    // Clocks per carrier step
    parameter int SMP_W   = flmc_pkg::CARRIER_W   // Sample width
) (
    input  wire logic            CLOCK,
    input  wire logic            RST_N,
    // Protection inputs from the analogue sensors, active high
    input  wire logic            SHORT_DET,
    input  wire logic            OVERTEMP_FLAG,
    input  wire logic            DC_OFFSET_DET,
    input  wire logic            UNDERVOLT_DET,
    input  wire logic            OVERVOLT_DET,
    // Control pins
    input  wire logic            SHUTDOWN_N,
    input  wire logic            MUTE_N,
    input  wire logic            MODULATION_SELECT,
    output var  logic            FAULT_FLAG_N,
    // Bridge halves; enable low while driving
    output var  logic [CH_N-1:0] POSITIVE_HALF_OUTPUT,
    output var  logic [CH_N-1:0] POSITIVE_HALF_OE_N,
    output var  logic [CH_N-1:0] NEGATIVE_HALF_OUTPUT,
    output var  logic [CH_N-1:0] NEGATIVE_HALF_OE_N,
    output var  logic            IRQ,
    // AXI4-Lite slave
    input  wire logic [7:0]      AWADDR,
    input  wire logic            AWVALID,
    output var  logic            AWREADY,
    input  wire logic [31:0]     WDATA,
    input  wire logic [3:0]      WSTRB,
    input  wire logic            WVALID,
    output var  logic            WREADY,
    output var  logic [1:0]      BRESP,
    output var  logic            BVALID,
    input  wire logic            BREADY,
    input  wire logic [7:0]      ARADDR,
    input  wire logic            ARVALID,
    output var  logic            ARREADY,
    output var  logic [31:0]     RDATA,
    output var  logic [1:0]      RRESP,
    output var  logic            RVALID,
    input  wire logic            RREADY
);

    localparam int DIV_W = (PWM_DIV > 1) ? $clog2(PWM_DIV) : 1;

    // Control and status state
    logic [31:0]               ctrl_q;        // Software control
    flmc_pkg::flmc_evt_s       irq_stat_q;    // Sticky interrupt events
    flmc_pkg::flmc_evt_s       irq_mask_q;    // Interrupt enables
    logic [31:0]               audio_q;       // Current samples
    flmc_pkg::flmc_evt_s       evt_now;       // Live fault picture
    flmc_pkg::flmc_evt_s       evt_prev_q;    // For rising-edge events
    logic [flmc_pkg::LATCH_N-1:0] latch_set;  // Latch set terms
    logic [flmc_pkg::LATCH_N-1:0] latch_q;    // Latched faults
    logic                      any_latch;
    logic                      hiz_req;
    flmc_pkg::flmc_bridge_e    bridge_q;
    logic                      bridge_hiz;
    // Carrier divider
    logic [DIV_W-1:0]          div_q;
    logic                      step_en_q;
    // Channel raw drive
    logic [CH_N-1:0]           pos_raw;
    logic [CH_N-1:0]           neg_raw;
    // AXI bookkeeping
    logic [7:0]                aw_addr_q;
    logic [31:0]               w_data_q;
    logic [3:0]                w_strb_q;
    logic                      aw_full_q;
    logic                      w_full_q;
    logic                      wr_go;
    logic                      wr_hit;
    logic [31:0]               wr_mask;
    logic [31:0]               rd_data;
    logic                      rd_hit;

    // Live conditions gathered into one event word
    always_comb begin
        evt_now.short_ckt = SHORT_DET;
        evt_now.over_temp = OVERTEMP_FLAG;
        evt_now.dc_offset = DC_OFFSET_DET;
        evt_now.undr_volt = UNDERVOLT_DET;
        evt_now.ovr_volt  = OVERVOLT_DET;
        latch_set = {evt_now.dc_offset, evt_now.over_temp, evt_now.short_ckt};
    end

    // Three protection latches; shutdown held low clears them.
    // Clearing on the low level rather than the release lets a fault
    // output looped into shutdown recover on its own.
    for (genvar i = 0; i < flmc_pkg::LATCH_N; i++) begin : g_latch
        flmc_fault_latch u_latch (
            .clk       (CLOCK),
            .rst_n     (RST_N),
            .set_i     (latch_set[i]),
            .clr_i     (!SHUTDOWN_N),
            .latched_q (latch_q[i])
        );
    end

    assign any_latch = |latch_q;

    // Every reason to float the bridge; supply faults act only while present
    assign hiz_req = any_latch
                   | evt_now.undr_volt | evt_now.ovr_volt
                   | !SHUTDOWN_N
                   | !MUTE_N
                   | ctrl_q[flmc_pkg::CTRL_MUTE_BIT];

    // Bridge state machine; leaving high impedance waits for carrier step
    // so the bridge starts driving on a carrier step, which need not be a period boundary
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            bridge_q <= flmc_pkg::BR_HIZ;
        end else begin
            unique case (bridge_q)
                flmc_pkg::BR_HIZ: begin
                    if (!hiz_req && step_en_q) begin
                        bridge_q <= flmc_pkg::BR_RUN;
                    end
                end
                flmc_pkg::BR_RUN: begin
                    if (hiz_req) begin
                        bridge_q <= flmc_pkg::BR_HIZ;
                    end
                end
                default: begin
                    bridge_q <= flmc_pkg::BR_HIZ;
                end
            endcase
        end
    end

    // Floats at once on a request, without waiting for the state update
    assign bridge_hiz = hiz_req || (bridge_q != flmc_pkg::BR_RUN);

    // Fault output low while any latch holds; supply faults do not show
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            FAULT_FLAG_N <= 1'b1;
        end else begin
            FAULT_FLAG_N <= !any_latch;
        end
    end

    // Carrier step enable divided from the system clock
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            div_q     <= '0;
            step_en_q <= 1'b0;
        end else if (div_q == DIV_W'(PWM_DIV - 1)) begin
            div_q     <= '0;
            step_en_q <= 1'b1;
        end else begin
            div_q     <= div_q + 1'b1;
            step_en_q <= 1'b0;
        end
    end

    // One modulator per channel; select pin picks the scheme
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        flmc_pwm_ch #(
            .W (SMP_W)
        ) u_ch (
            .clk       (CLOCK),
            .rst_n     (RST_N),
            .step_en   (step_en_q),
            .single_md (MODULATION_SELECT),
            .sample    (audio_q[c*SMP_W +: SMP_W]),
            .pos_q     (pos_raw[c]),
            .neg_q     (neg_raw[c])
        );
    end

    // Output stage: drive low and release enable whenever floating
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            POSITIVE_HALF_OUTPUT <= '0;
            NEGATIVE_HALF_OUTPUT <= '0;
            POSITIVE_HALF_OE_N   <= '1;
            NEGATIVE_HALF_OE_N   <= '1;
        end else if (bridge_hiz) begin
            POSITIVE_HALF_OUTPUT <= '0;
            NEGATIVE_HALF_OUTPUT <= '0;
            POSITIVE_HALF_OE_N   <= '1;
            NEGATIVE_HALF_OE_N   <= '1;
        end else begin
            POSITIVE_HALF_OUTPUT <= pos_raw;
            NEGATIVE_HALF_OUTPUT <= neg_raw;
            POSITIVE_HALF_OE_N   <= '0;
            NEGATIVE_HALF_OE_N   <= '0;
        end
    end

    // Interrupt events: rising edges of each live condition
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            evt_prev_q <= '0;
        end else begin
            evt_prev_q <= evt_now;
        end
    end

    // Sticky status, any write clears every bit in its strobed byte lanes; a new event beats the clear
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q
                & ~((wr_go && wr_hit && aw_addr_q == flmc_pkg::REG_IRQ_STATUS)
                    ? wr_mask[flmc_pkg::EVT_W-1:0] : '0))
                | (evt_now & ~evt_prev_q);
        end
    end

    // Level interrupt while any unmasked event is pending
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Byte-lane mask from the held strobes
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_mask[b*8 +: 8] = {8{w_strb_q[b]}};
        end
    end

    assign wr_go  = aw_full_q && w_full_q && !BVALID;
    assign wr_hit = (aw_addr_q == flmc_pkg::REG_CTRL)
                 || (aw_addr_q == flmc_pkg::REG_IRQ_STATUS)
                 || (aw_addr_q == flmc_pkg::REG_IRQ_MASK)
                 || (aw_addr_q == flmc_pkg::REG_AUDIO);

    // Write address channel, taken independently of data
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            AWREADY   <= 1'b1;
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (AWVALID && AWREADY) begin
            AWREADY   <= 1'b0;
            aw_full_q <= 1'b1;
            aw_addr_q <= {AWADDR[7:2], 2'h0};
        end else if (BVALID && BREADY) begin
            AWREADY   <= 1'b1;
            aw_full_q <= 1'b0;
        end
    end

    // Write data channel
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            WREADY   <= 1'b1;
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (WVALID && WREADY) begin
            WREADY   <= 1'b0;
            w_full_q <= 1'b1;
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
        end else if (BVALID && BREADY) begin
            WREADY   <= 1'b1;
            w_full_q <= 1'b0;
        end
    end

    // Write response once both halves are in
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            BVALID <= 1'b0;
            BRESP  <= flmc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP  <= wr_hit ? flmc_pkg::RESP_OKAY : flmc_pkg::RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Writable registers; status is read-only and ignores writes
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q     <= flmc_pkg::CTRL_RESET;
            irq_mask_q <= '0;
            audio_q    <= '0;
        end else if (wr_go) begin
            if (aw_addr_q == flmc_pkg::REG_CTRL) begin
                ctrl_q <= (ctrl_q & ~wr_mask) | (w_data_q & wr_mask);
            end
            if (aw_addr_q == flmc_pkg::REG_IRQ_MASK) begin
                irq_mask_q <= (irq_mask_q & ~wr_mask[flmc_pkg::EVT_W-1:0])
                            | (w_data_q[flmc_pkg::EVT_W-1:0]
                               & wr_mask[flmc_pkg::EVT_W-1:0]);
            end
            if (aw_addr_q == flmc_pkg::REG_AUDIO) begin
                audio_q <= (audio_q & ~wr_mask) | (w_data_q & wr_mask);
            end
        end
    end

    // Read decode; unmapped reads return zero with an error
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        unique case ({ARADDR[7:2], 2'h0})
            flmc_pkg::REG_CTRL: begin
                rd_data = ctrl_q;
            end
            flmc_pkg::REG_STATUS: begin
                rd_data[flmc_pkg::EVT_W-1:0] =
                    {evt_now.ovr_volt, evt_now.undr_volt, latch_q};
                rd_data[flmc_pkg::STAT_SHDN_BIT]   = !SHUTDOWN_N;
                rd_data[flmc_pkg::STAT_SEL_BIT]    = MODULATION_SELECT;
                rd_data[flmc_pkg::STAT_FAULT_BIT]  = !FAULT_FLAG_N;
                rd_data[flmc_pkg::STAT_HIZ_BIT]    = bridge_hiz;
            end
            flmc_pkg::REG_IRQ_STATUS: begin
                rd_data[flmc_pkg::EVT_W-1:0] = irq_stat_q;
            end
            flmc_pkg::REG_IRQ_MASK: begin
                rd_data[flmc_pkg::EVT_W-1:0] = irq_mask_q;
            end
            flmc_pkg::REG_AUDIO: begin
                rd_data = audio_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= '0;
            RRESP   <= flmc_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_data;
            RRESP   <= rd_hit ? flmc_pkg::RESP_OKAY : flmc_pkg::RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: bench/flmc_props.sv
`timescale 1ns/1ps
`default_nettype none

// Protection timing seen from the pins only
module flmc_props #(
    parameter int CH_N = 2
) (
    input wire logic            CLOCK,
    input wire logic            RST_N,
    input wire logic            SHORT_DET,
    input wire logic            OVERTEMP_FLAG,
    input wire logic            DC_OFFSET_DET,
    input wire logic            UNDERVOLT_DET,
    input wire logic            OVERVOLT_DET,
    input wire logic            SHUTDOWN_N,
    input wire logic            FAULT_FLAG_N,
    input wire logic [CH_N-1:0] POSITIVE_HALF_OE_N,
    input wire logic [CH_N-1:0] NEGATIVE_HALF_OE_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Whole bridge floating
    wire hiz = &POSITIVE_HALF_OE_N && &NEGATIVE_HALF_OE_N;

    AST_SHORT_FAULT: assert property (SHORT_DET |-> ##2 !FAULT_FLAG_N)
        else $error("short did not pull fault low");
    AST_SHORT_HIZ: assert property (SHORT_DET |-> ##2 hiz)
        else $error("short did not float bridge");
    AST_TEMP_FAULT: assert property (OVERTEMP_FLAG |-> ##2 (hiz && !FAULT_FLAG_N))
        else $error("over temperature not latched");
    AST_OFFSET_FAULT: assert property (DC_OFFSET_DET |-> ##2 (hiz && !FAULT_FLAG_N))
        else $error("offset fault not latched");
    // Fault holds while shutdown stays high
    AST_LATCH_HOLD: assert property ((SHUTDOWN_N [*3] ##0 !FAULT_FLAG_N) |=> !FAULT_FLAG_N)
        else $error("fault released without shutdown");
    AST_CLEAR: assert property ((!SHUTDOWN_N && !SHORT_DET && !OVERTEMP_FLAG
        && !DC_OFFSET_DET) [*2] |=> FAULT_FLAG_N)
        else $error("shutdown did not release fault");
    AST_SHDN_HIZ: assert property (!SHUTDOWN_N |=> hiz)
        else $error("bridge driven in shutdown");
    AST_SUPPLY_HIZ: assert property ((UNDERVOLT_DET || OVERVOLT_DET) |=> hiz)
        else $error("bridge driven on supply fault");
    AST_DRIVE_CLEAN: assert property (!hiz |-> FAULT_FLAG_N)
        else $error("bridge driven with fault active");
endmodule

bind flmc_top flmc_props #(.CH_N(CH_N)) u_props (
    .CLOCK(CLOCK), .RST_N(RST_N), .SHORT_DET(SHORT_DET), .OVERTEMP_FLAG(OVERTEMP_FLAG),
    .DC_OFFSET_DET(DC_OFFSET_DET), .UNDERVOLT_DET(UNDERVOLT_DET),
    .OVERVOLT_DET(OVERVOLT_DET), .SHUTDOWN_N(SHUTDOWN_N), .FAULT_FLAG_N(FAULT_FLAG_N),
    .POSITIVE_HALF_OE_N(POSITIVE_HALF_OE_N), .NEGATIVE_HALF_OE_N(NEGATIVE_HALF_OE_N));

`default_nettype wire

// File: bench/flmc_board.sv
`timescale 1ns/1ps
`default_nettype none

// Board logic on the control pins
module flmc_board (
    input  wire logic fault_n,    // Amplifier fault output
    input  wire logic loop_en,    // Strap: fault wired back to shutdown
    input  wire logic shdn_req_n, // Host shutdown request
    input  wire logic mute_req_n, // Host mute request
    output var  logic shutdown_n,
    output var  logic mute_n
);
    // Host pulses shutdown low to clear; looped fault does it alone
    always_comb shutdown_n = shdn_req_n & (fault_n | !loop_en);
    // Inverting transistor keeps restarts floating while fault is low
    always_comb mute_n = mute_req_n & (fault_n | !loop_en);
endmodule

`default_nettype wire

// File: bench/flmc_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module testbench;
    logic        CLOCK = 0;
    logic        RST_N = 0;
    logic [4:0]  ev = 0;          // Sensor events, status bit order
    logic        shd_n = 1;       // Host shutdown request
    logic        mut_n = 1;       // Host mute request
    logic        loop_en = 0;     // Fault looped to shutdown
    logic        sel = 0;         // Modulation select pin
    logic        sdn, mtn, flt_n, irq;
    logic [1:0]  pos, poe, neg, noe;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic        awv = 0, wv = 0, arv = 0, awr, wr, arr, bv, rv;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] seed = 32'hfe94c409;
    int          fails = 0, n_compared = 0;

    always #5 CLOCK = ~CLOCK;

    flmc_board u_board (.fault_n(flt_n), .loop_en(loop_en), .shdn_req_n(shd_n),
        .mute_req_n(mut_n), .shutdown_n(sdn), .mute_n(mtn));

    // Ready inputs held high: the bench never stalls answers
    flmc_top uut (.CLOCK(CLOCK), .RST_N(RST_N), .SHORT_DET(ev[0]), .OVERTEMP_FLAG(ev[1]),
        .DC_OFFSET_DET(ev[2]), .UNDERVOLT_DET(ev[3]), .OVERVOLT_DET(ev[4]),
        .SHUTDOWN_N(sdn), .MUTE_N(mtn), .MODULATION_SELECT(sel), .FAULT_FLAG_N(flt_n),
        .POSITIVE_HALF_OUTPUT(pos), .POSITIVE_HALF_OE_N(poe), .NEGATIVE_HALF_OUTPUT(neg),
        .NEGATIVE_HALF_OE_N(noe), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awv),
        .AWREADY(awr), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wv), .WREADY(wr),
        .BRESP(bresp), .BVALID(bv), .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arv),
        .ARREADY(arr), .RDATA(rdata), .RRESP(rresp), .RVALID(rv), .RREADY(1'b1));

    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        forever begin
            @(posedge CLOCK);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            if (bv) begin
                rsp = bresp;
                break;
            end
        end
    endtask

    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arv <= 1;
        forever begin
            @(posedge CLOCK);
            if (arr) arv <= 0;
            if (rv) begin
                rd = rdata;
                rsp = rresp;
                break;
            end
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // High steps per carrier period for one half
    function automatic int exp_d(input logic md, input logic signed [7:0] s, input logic ng);
        int h;
        h = md ? int'(s) : int'(s) >>> 1;
        h = (md ? 256 * flmc_pkg::IDLE_PERCENT : 256 * flmc_pkg::HALF_PERCENT) / 100
            + (ng ? -h : h);
        return h < 0 ? 0 : (h > 256 ? 256 : h);
    endfunction

    // One full carrier period, sampled each edge
    task automatic meas(output integer p, n, q, m);
        p = 0;
        n = 0;
        q = 0;
        m = 0;
        repeat (256) begin
            @(posedge CLOCK);
            p += pos[0];
            n += neg[0];
            q += pos[1];
            m += neg[1];
        end
    endtask

    task automatic end_of_test;
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Whole run is near 10500 cycles
    initial begin
        cyc(40000);
        fails++;
        end_of_test;
    end

    initial begin
        integer p, n, q, m;
        logic signed [7:0] s, r;
        cyc(20);
        RST_N <= 1;
        cyc(1);
        axr(flmc_pkg::REG_CTRL);
        `CHK("ctrl", flmc_pkg::CTRL_RESET, rd)
        axr(flmc_pkg::REG_IRQ_MASK);
        `CHK("mask", 32'h0, rd)
        axr(8'h40);
        `CHK("rresp", flmc_pkg::RESP_SLVERR, rsp)
        axw(8'h40, 32'h1);
        `CHK("bresp", flmc_pkg::RESP_SLVERR, rsp)
        axw(flmc_pkg::REG_STATUS, 32'hffff_ffff);
        `CHK("bresp_ro", flmc_pkg::RESP_SLVERR, rsp)
        `CHK("muted", 2'h3, poe)
        axw(flmc_pkg::REG_CTRL, 32'h0);
        // Carrier sweep: corners first, then random samples
        for (int k = 0; k < 12; k++) begin
            s = (k % 6 == 0) ? 8'h00 : (k % 6 == 1) ? 8'h7f : (k % 6 == 2) ? 8'h80 : seed[7:0];
            r = seed[15:8];
            seed = lfsr(seed);
            sel <= k / 6;
            axw(flmc_pkg::REG_AUDIO, {16'h0, r, s});
            cyc(600);
            meas(p, n, q, m);
            `CHK("pos", exp_d(k / 6, s, 0), p)
            `CHK("neg", exp_d(k / 6, s, 1), n)
            `CHK("pos_r", exp_d(k / 6, r, 0), q)
            `CHK("neg_r", exp_d(k / 6, r, 1), m)
            `CHK("drive", 2'h0, noe)
        end
        mut_n <= 0;
        cyc(3);
        `CHK("mute", 2'h3, poe)
        mut_n <= 1;
        axw(flmc_pkg::REG_IRQ_MASK, 32'h15);
        // Every protection event, odd ones masked
        for (int i = 0; i < 5; i++) begin
            ev <= 5'h1 << i;
            cyc(3);
            `CHK("oe_hiz", 2'h3, noe)
            `CHK("irq", (i % 2 == 0), irq)
            ev <= 0;
            cyc(3);
            `CHK("fault", (i > 2), flt_n)
            `CHK("oe_hold", (i > 2) ? 2'h0 : 2'h3, poe)
            axr(flmc_pkg::REG_STATUS);
            `CHK("stat", (i < 3), rd[i])
            axw(flmc_pkg::REG_IRQ_STATUS, 32'h1 << i);
            cyc(2);
            `CHK("irq_clr", 1'b0, irq)
            shd_n <= 0;
            cyc(3);
            `CHK("fault_rel", 1'b1, flt_n)
            `CHK("oe_shdn", 2'h3, poe)
            shd_n <= 1;
            cyc(3);
            `CHK("oe_run", 2'h0, poe)
        end
        // Fault wired back to shutdown recovers by itself
        loop_en <= 1;
        ev <= 5'h1;
        cyc(1);
        ev <= 0;
        cyc(12);
        `CHK("auto_fault", 1'b1, flt_n)
        `CHK("auto_oe", 2'h0, poe)
        axr(flmc_pkg::REG_IRQ_STATUS);
        `CHK("auto_evt", 1'b1, rd[0])
        end_of_test;
    end
endmodule

`default_nettype wire
